// ==== tics_map.svh ====
// Register offsets, field positions, codes and reset values of the touch sequencer
`ifndef TICS_MAP_SVH
`define TICS_MAP_SVH

`define TICS_A_STATUS 8'h00
`define TICS_A_CTRL 8'h04
`define TICS_A_EPULSE 8'h08
`define TICS_A_PUTIME 8'h0c
`define TICS_A_CMD 8'h10
`define TICS_A_APER 8'h14
`define TICS_A_FIFO 8'h18
`define TICS_A_FCNT 8'h1c
`define TICS_A_RES_HI 4'h2

`define TICS_C_EDGE 0
`define TICS_C_ACM 1
`define TICS_C_APER 2
`define TICS_C_MASK_HI 7
`define TICS_C_MASK_LO 4

`define TICS_CTRL_RST 8'h30
`define TICS_EPULSE_RST 16'h0100
`define TICS_PUTIME_RST 16'h0040
`define TICS_APER_RST 12'h010

`define TICS_CMD_SETUP_HI 5'h0d
`define TICS_CMD_MEAS_HI 5'h0f
`define TICS_CMD_XY 8'h70
`define TICS_CMD_XYZ1 8'h72
`define TICS_CMD_XYZ 8'h74
`define TICS_MASK_XY 4'h3
`define TICS_MASK_XYZ1 4'h7
`define TICS_MASK_XYZ 4'hf

`define TICS_EVENT_TAG_TOUCH 2'h0
`define TICS_EVENT_TAG_MID 2'h1
`define TICS_EVENT_TAG_REL 2'h2
`define TICS_EVENT_TAG_BUSY 2'h3
`define TICS_MEASUREMENT_TAG_X 2'h0
`define TICS_MEASUREMENT_TAG_Y 2'h1
`define TICS_PEND_WORD 16'hffff

`define TICS_FIFO_DEPTH 4'h8
`define TICS_ONE3 3'h1
`define TICS_ONE4 4'h1
`define TICS_ONE16 16'h0001

`endif

// ==== tics_pkg.sv ====
// Types shared by the touch sequencer
package tics_pkg;

  typedef enum logic [2:0] {
    st_tdm,
    st_lpm,
    st_setup,
    st_conv,
    st_puf,
    st_tag
  } tics_st_t;

  typedef struct packed {
    logic [1:0] tsync;
    logic touch_prev;
    tics_st_t st;
    logic [7:0] ctrl;
    logic [15:0] epulse;
    logic [15:0] putime;
    logic [11:0] aper;
    logic [15:0] cnt;
    logic [15:0] irq_cnt;
    logic irq_n;
    logic [3:0] mask;
    logic [3:0] done_mask;
    logic [1:0] sel;
    logic hold;
    logic first;
    logic tch;
    logic adc_go;
    logic [3:0][15:0] res;
    logic [3:0] pend;
    logic [7:0][15:0] fifo;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [3:0] fcnt;
    logic have_last;
    logic [11:0] lastx;
    logic [11:0] lasty;
    logic ap_wr;
    logic ap_rd;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } tics_reg_t;

endpackage : tics_pkg

// ==== tics_touch_seq.sv ====
// Touch detect, measurement sequencing, tagging and touch interrupt with AHB-Lite registers
`timescale 1ns/10ps
`include "tics_map.svh"
// What this block does
// RULE1: Autonomous results go to FIFO, interrupt each write
// RULE2: FIFO readable by host at any time
// RULE3: Autonomous aperture suppresses positions inside rectangle
// RULE4: Direct takes setup/measure/combined; autonomous combined only
// RULE5: Host starts every direct-mode panel operation
// RULE6: Level or edge interrupt mode by configuration
// RULE7: Level mode: idle detect, irq low on touch
// RULE8: Level mode: irq low during host operations
// RULE9: Hold clear: touch check for pullup time, tag
// RULE10: Level mode: back to detect, irq follows touch
// RULE11: Level event tags: touch, unused, none, busy
// RULE12: Measurement tags: X, Y, Z1, Z2
// RULE13: Release during detect idle gives no tag
// RULE14: Edge mode touched: untimed idle, no monitoring
// RULE15: Edge event tags: initial, midpress, release
// RULE16: Edge mode after release: detect, irq new touch
// RULE17: Edge mode new touch: irq pulse programmed length
// RULE18: Edge mode touched: low power; release: detect
// RULE19: Edge mode without release: no new touches
// RULE20: Host keeps issuing hold-clear commands until release
// RULE21: Host polls status when irq line shared
// RULE22: Result word: data, measurement tag, event tag
// RULE23: Pending result reads all ones, event busy
// RULE24: Hold set keeps setup, idle and irq unchanged
// RULE25: Touch comparator synchronised before use
module tics_touch_seq (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic touch_det,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  output logic adc_start,
  output logic [1:0] adc_sel,
  output logic panel_tdm,
  output logic panel_drive,
  output logic [1:0] panel_sel,
  output logic touch_irq_n
);

  logic [1:0] rst_sync_q;
  logic rst_n;
  tics_pkg::tics_reg_t r_q;
  tics_pkg::tics_reg_t r_d;

  // Release the asynchronous reset on the core clock
  // Two stages, so the release edge never lands in a setup window
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [1:0] tics_low(input logic [3:0] m);
    logic [1:0] idx;
    idx = 2'h0;
    if (m[0]) begin
      idx = 2'h0;
    end else if (m[1]) begin
      idx = 2'h1;
    end else if (m[2]) begin
      idx = 2'h2;
    end else if (m[3]) begin
      idx = 2'h3;
    end
    return idx;
  endfunction : tics_low

  function automatic logic [11:0] tics_dist(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] dv;
    dv = (a > b) ? (a - b) : (b - a);
    return dv;
  endfunction : tics_dist

  logic touch;
  logic edge_mode;
  logic autonomous_conversion_mode;
  logic busy;
  logic addr_ok;
  logic pop;
  logic push;
  logic [15:0] word;
  logic [15:0] push_word;
  logic [1:0] b;
  logic [1:0] event_tag;
  logic [3:0] bit_b;
  logic [3:0] rest;
  logic [7:0] cmd;
  logic new_touch;
  logic in_aper;

  assign hresp = 1'b0;
  assign hreadyout = !r_q.ap_rd;
  assign hrdata = r_q.rdata;
  assign touch_irq_n = r_q.irq_n;
  assign adc_start = r_q.adc_go;
  assign adc_sel = r_q.sel;
  assign panel_tdm = (r_q.st == tics_pkg::st_tdm);
  assign panel_drive = (r_q.st == tics_pkg::st_setup) || (r_q.st == tics_pkg::st_conv);
  assign panel_sel = r_q.sel;

  always_comb begin
    r_d = r_q;
    touch = r_q.tsync[1]; // [RULE25]
    edge_mode = r_q.ctrl[`TICS_C_EDGE]; // [RULE6]
    autonomous_conversion_mode = r_q.ctrl[`TICS_C_ACM];
    busy = (r_q.st == tics_pkg::st_conv) || (r_q.st == tics_pkg::st_puf) ||
           (r_q.st == tics_pkg::st_tag);
    addr_ok = hsel && htrans[1] && hready;
    pop = 1'b0;
    push = 1'b0;
    push_word = 16'h0000;
    word = 16'h0000;
    b = tics_low(r_q.done_mask);
    bit_b = `TICS_ONE4 << b;
    rest = 4'h0;
    event_tag = `TICS_EVENT_TAG_TOUCH;
    cmd = hwdata[7:0];
    in_aper = 1'b0;
    // Comparator passes two flops; only the second one is read
    r_d.tsync = {r_q.tsync[0], touch_det}; // [RULE25]
    r_d.touch_prev = touch;
    r_d.adc_go = 1'b0;
    // Edge pulse counter; armed by a new touch in detect idle and by each FIFO write
    // A touch already present when detect idle resumes raises no pulse
    new_touch = touch && !r_q.touch_prev && (r_q.st == tics_pkg::st_tdm) &&
                edge_mode && !autonomous_conversion_mode; // [RULE16] [RULE19]
    if (r_q.irq_cnt != 16'h0000) begin
      r_d.irq_cnt = r_q.irq_cnt - `TICS_ONE16;
    end
    if (new_touch) begin
      r_d.irq_cnt = r_q.epulse; // [RULE17]
    end

    // Bus address phase
    r_d.ap_wr = 1'b0;
    if (addr_ok) begin
      r_d.ap_wr = hwrite;
      r_d.ap_rd = !hwrite;
      r_d.ap_addr = haddr[7:0];
    end

    // Read wait cycle: data is formed here and held in a flop
    if (r_q.ap_rd) begin
      r_d.ap_rd = 1'b0;
      r_d.rdata = 32'h0000_0000;
      if (r_q.ap_addr[7:4] == `TICS_A_RES_HI && r_q.ap_addr[1:0] == 2'h0) begin
        r_d.rdata[15:0] = r_q.pend[r_q.ap_addr[3:2]] ? `TICS_PEND_WORD :
                          r_q.res[r_q.ap_addr[3:2]]; // [RULE23]
      end else begin
        unique case (r_q.ap_addr)
          `TICS_A_STATUS: r_d.rdata[10:0] = {3'(r_q.st), 3'h0, (r_q.fcnt == 4'h0),
                                            (r_q.fcnt == `TICS_FIFO_DEPTH), busy,
                                            touch, !r_q.irq_n}; // [RULE21]
          `TICS_A_CTRL: r_d.rdata[7:0] = r_q.ctrl;
          `TICS_A_EPULSE: r_d.rdata[15:0] = r_q.epulse;
          `TICS_A_PUTIME: r_d.rdata[15:0] = r_q.putime;
          `TICS_A_APER: r_d.rdata[11:0] = r_q.aper;
          `TICS_A_FCNT: r_d.rdata[3:0] = r_q.fcnt;
          `TICS_A_FIFO: begin
            // Host may drain the FIFO at any moment
            if (r_q.fcnt != 4'h0) begin
              r_d.rdata[15:0] = r_q.fifo[r_q.rp]; // [RULE2]
              pop = 1'b1;
            end else begin
              r_d.rdata[15:0] = `TICS_PEND_WORD;
            end
          end
          default: r_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Bus data phase of a write
    if (r_q.ap_wr) begin
      unique case (r_q.ap_addr)
        `TICS_A_CTRL: r_d.ctrl = hwdata[7:0];
        `TICS_A_EPULSE: r_d.epulse = hwdata[15:0];
        `TICS_A_PUTIME: r_d.putime = hwdata[15:0];
        `TICS_A_APER: r_d.aper = hwdata[11:0];
        `TICS_A_CMD: begin
          // Commands only in direct mode and while not converting, in pullup or tagging
          if (!autonomous_conversion_mode && !busy) begin // [RULE4] [RULE5]
            if (cmd[7:3] == `TICS_CMD_SETUP_HI && cmd[0]) begin
              r_d.st = tics_pkg::st_setup;
              r_d.sel = cmd[2:1];
            end else if (cmd[7:3] == `TICS_CMD_MEAS_HI) begin
              if (r_q.st == tics_pkg::st_setup && r_q.sel != cmd[2:1]) begin
                r_d.st = tics_pkg::st_lpm;
              end else begin
                r_d.mask = `TICS_ONE4 << cmd[2:1];
                r_d.done_mask = `TICS_ONE4 << cmd[2:1];
                r_d.pend = r_q.pend | (`TICS_ONE4 << cmd[2:1]);
                r_d.sel = cmd[2:1];
                r_d.hold = cmd[0];
                r_d.adc_go = 1'b1;
                r_d.st = tics_pkg::st_conv;
              end
            end else if (cmd == `TICS_CMD_XY || cmd == `TICS_CMD_XYZ1 ||
                         cmd == `TICS_CMD_XYZ) begin
              rest = (cmd == `TICS_CMD_XY) ? `TICS_MASK_XY :
                     (cmd == `TICS_CMD_XYZ1) ? `TICS_MASK_XYZ1 : `TICS_MASK_XYZ;
              // Every location of a combined command reads pending until its own word is tagged
              r_d.mask = rest;
              r_d.done_mask = rest;
              r_d.pend = r_q.pend | rest; // [RULE23]
              r_d.sel = 2'h0;
              r_d.hold = 1'b0;
              r_d.adc_go = 1'b1;
              r_d.st = tics_pkg::st_conv;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Sequencer
    unique case (r_q.st)
      tics_pkg::st_tdm: begin
        // Autonomous scan starts on touch with the configured combined set
        if (autonomous_conversion_mode && touch && r_q.ctrl[`TICS_C_MASK_HI:`TICS_C_MASK_LO] != 4'h0) begin
          rest = r_q.ctrl[`TICS_C_MASK_HI:`TICS_C_MASK_LO]; // [RULE4]
          r_d.mask = rest;
          r_d.done_mask = rest;
          r_d.sel = tics_low(rest);
          r_d.hold = 1'b0;
          r_d.adc_go = 1'b1;
          r_d.st = tics_pkg::st_conv;
        end
      end
      tics_pkg::st_lpm: begin
        // No touch monitoring here until the host converts again
        // Level mode must keep watching the panel, so it never rests here
        if (!edge_mode && !autonomous_conversion_mode) begin
          r_d.st = tics_pkg::st_tdm; // [RULE7] [RULE10]
        end
      end // [RULE14] [RULE19]
      tics_pkg::st_setup: begin
        // Panel stays configured for the selected measurement
      end
      tics_pkg::st_conv: begin
        if (adc_done && !r_q.adc_go) begin
          r_d.res[r_q.sel][15:4] = adc_data; // [RULE22]
          rest = r_q.mask & ~(`TICS_ONE4 << r_q.sel);
          r_d.mask = rest;
          if (rest != 4'h0) begin
            r_d.sel = tics_low(rest);
            r_d.adc_go = 1'b1;
          end else if (r_q.hold) begin
            // Tag at once; setup, idle mode and irq state stay as they are
            r_d.tch = touch; // [RULE24]
            r_d.st = tics_pkg::st_tag;
          end else begin
            r_d.cnt = r_q.putime; // [RULE9]
            r_d.st = tics_pkg::st_puf;
          end
        end
      end
      tics_pkg::st_puf: begin
        if (r_q.cnt != 16'h0000) begin
          r_d.cnt = r_q.cnt - `TICS_ONE16;
        end else begin
          r_d.tch = touch; // [RULE9]
          r_d.st = tics_pkg::st_tag;
        end
      end
      tics_pkg::st_tag: begin
        if (r_q.done_mask != 4'h0) begin
          // One word per cycle keeps the FIFO write port single
          if (!r_q.tch) begin
            event_tag = `TICS_EVENT_TAG_REL; // [RULE11] [RULE15]
          end else if ((edge_mode || autonomous_conversion_mode) && !r_q.first) begin
            event_tag = `TICS_EVENT_TAG_MID; // [RULE15]
          end else begin
            event_tag = `TICS_EVENT_TAG_TOUCH; // [RULE11]
          end
          word = {r_q.res[b][15:4], b, event_tag}; // [RULE12] [RULE22]
          r_d.res[b] = word;
          r_d.pend = r_d.pend & ~bit_b;
          r_d.done_mask = r_q.done_mask & ~bit_b;
          if (autonomous_conversion_mode) begin
            if (b == `TICS_MEASUREMENT_TAG_X) begin
              in_aper = tics_dist(r_q.res[b][15:4], r_q.lastx) <= r_q.aper;
            end else if (b == `TICS_MEASUREMENT_TAG_Y) begin
              in_aper = tics_dist(r_q.res[b][15:4], r_q.lasty) <= r_q.aper;
            end
            // Positions inside the rectangle are not reported again
            if (!(r_q.ctrl[`TICS_C_APER] && r_q.have_last && r_q.tch && in_aper)) begin
              push = 1'b1; // [RULE1] [RULE3]
              push_word = word;
              if (b == `TICS_MEASUREMENT_TAG_X) begin
                r_d.lastx = r_q.res[b][15:4];
              end
              if (b == `TICS_MEASUREMENT_TAG_Y) begin
                r_d.lasty = r_q.res[b][15:4];
              end
            end
          end
        end else if (r_q.hold) begin
          r_d.st = tics_pkg::st_setup; // [RULE24]
        end else if (autonomous_conversion_mode) begin
          r_d.first = !r_q.tch;
          r_d.have_last = r_q.tch;
          r_d.st = tics_pkg::st_tdm;
        end else if (edge_mode && r_q.tch) begin
          r_d.first = 1'b0;
          r_d.st = tics_pkg::st_lpm; // [RULE14] [RULE18]
        end else begin
          r_d.first = 1'b1;
          r_d.st = tics_pkg::st_tdm; // [RULE10] [RULE16] [RULE18]
        end
      end
      default: r_d.st = tics_pkg::st_tdm;
    endcase

    // FIFO; a full FIFO drops the newest word
    if (push && (r_q.fcnt != `TICS_FIFO_DEPTH || pop)) begin
      r_d.fifo[r_q.wp] = push_word; // [RULE1]
      r_d.wp = r_q.wp + `TICS_ONE3;
      r_d.irq_cnt = r_q.epulse; // [RULE1]
    end else begin
      push = 1'b0;
    end
    if (pop) begin
      r_d.rp = r_q.rp + `TICS_ONE3; // [RULE2]
    end
    r_d.fcnt = r_q.fcnt + {3'h0, push} - {3'h0, pop};

    // Interrupt pin: level mode follows touch in detect idle, low while busy
    if (edge_mode || autonomous_conversion_mode) begin
      r_d.irq_n = (r_d.irq_cnt == 16'h0000); // [RULE17]
    end else begin
      // Release seen only in detect idle just lifts the line, no tag
      r_d.irq_n = !((r_q.st == tics_pkg::st_tdm && touch) ||
                    r_q.st == tics_pkg::st_setup || busy); // [RULE7] [RULE8] [RULE10] [RULE13]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '0;
      r_q.st <= tics_pkg::st_tdm;
      r_q.ctrl <= `TICS_CTRL_RST;
      r_q.epulse <= `TICS_EPULSE_RST;
      r_q.putime <= `TICS_PUTIME_RST;
      r_q.aper <= `TICS_APER_RST;
      r_q.irq_n <= 1'b1;
      r_q.first <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

endmodule : tics_touch_seq

// ==== tics_adc_model.sv ====
// Converter and panel model answering conversion starts from the sequencer
`timescale 1ns/10ps
module tics_adc_model (
  input wire logic core_clk,
  input wire logic adc_start,
  input wire logic [1:0] adc_sel,
  input wire logic slow,
  output logic adc_done,
  output logic [11:0] adc_data
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [1:0] sel_q;
  initial begin
    adc_done = 1'b0;
    adc_data = 12'h000;
    busy_q = 1'b0;
    cnt_q = 4'h0;
    sel_q = 2'h0;
  end
  // Data only holds in the done cycle; otherwise it toggles so stale values never pass
  always @(posedge core_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start) begin
      busy_q <= 1'b1;
      sel_q <= adc_sel;
      cnt_q <= slow ? 4'h9 : 4'h2;
    end else if (busy_q) begin
      if (cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= {sel_q, 10'h2a5};
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : tics_adc_model

// ==== tics_touch_seq_sva.sv ====
// Port-level assertions for the touch sequencer
`timescale 1ns/10ps
`include "tics_map.svh"
module tics_touch_seq_sva (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic adc_start,
  input wire logic [1:0] adc_sel,
  input wire logic [1:0] panel_sel,
  input wire logic panel_tdm,
  input wire logic panel_drive,
  input wire logic touch_irq_n
);
  logic rd_go;
  logic wr_go;
  logic ctrl_wr_q;
  logic [1:0] mode_q;
  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  assign wr_go = hsel && htrans[1] && hready && hwrite;
  // Shadow of the mode bits, since the checker cannot see the control register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_wr_q <= 1'b0;
      mode_q <= 2'h0;
    end else begin
      ctrl_wr_q <= wr_go && (haddr[7:0] == `TICS_A_CTRL);
      if (ctrl_wr_q) mode_q <= hwdata[1:0];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    rd_go |=> s_rd_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    wr_go |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_no_spur;
    !hreadyout |-> $past(rd_go);
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("wait state without read");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_start_pulse;
    adc_start |=> !adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
  property p_sel_match;
    panel_sel == adc_sel;
  endproperty
  a_sel_match: assert property (p_sel_match) else $error("panel and adc select differ");
  property p_idle_excl;
    !(panel_tdm && panel_drive);
  endproperty
  a_idle_excl: assert property (p_idle_excl) else $error("detect and drive together");
  property p_lvl_busy;
    (mode_q == 2'h0) && panel_drive |=> !touch_irq_n;
  endproperty
  a_lvl_busy: assert property (p_lvl_busy) else $error("irq high during operation");
  property p_edge_pulse;
    (mode_q == 2'h1) && $fell(touch_irq_n) |-> !touch_irq_n [*3];
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge irq pulse short");
endmodule : tics_touch_seq_sva
bind tics_touch_seq tics_touch_seq_sva u_sva (.core_clk(core_clk), .arst_n(arst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .adc_start(adc_start),
  .adc_sel(adc_sel), .panel_sel(panel_sel), .panel_tdm(panel_tdm),
  .panel_drive(panel_drive), .touch_irq_n(touch_irq_n));

// ==== tics_touch_seq_tb.sv ====
// Register-level testbench of the touch sequencer
`timescale 1ns/10ps
`include "tics_map.svh"
module tics_touch_seq_tb;
  logic core_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, touch_det = 1'b0;
  logic slow = 1'b0, hready, hreadyout, hresp, adc_done, adc_start, panel_tdm;
  logic panel_drive, touch_irq_n;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, adc_sel, panel_sel;
  logic [11:0] adc_data;
  int n_fail = 0, num_checks = 0, cyc = 0, w, n;
  assign hready = hreadyout;
  always #2.5 core_clk = ~core_clk;
  tics_touch_seq DUT (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .touch_det(touch_det),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start), .adc_sel(adc_sel),
    .panel_tdm(panel_tdm), .panel_drive(panel_drive), .panel_sel(panel_sel),
    .touch_irq_n(touch_irq_n));
  tics_adc_model u_adc (.core_clk(core_clk), .adc_start(adc_start), .adc_sel(adc_sel),
    .slow(slow), .adc_done(adc_done), .adc_data(adc_data));
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd_chk
  task automatic st_chk(input logic [2:0] exp);
    bus(1'b0, `TICS_A_STATUS, 32'h0);
    chk({29'h0, r[10:8]}, {29'h0, exp});
  endtask : st_chk
  // Poll a result until its busy tag clears; a dead sequencer ends at the bound
  task automatic wait_res(input logic [7:0] a);
    w = 0;
    do begin
      bus(1'b0, a, 32'h0);
      w++;
    end while (r[1:0] === 2'h3 && w < 200);
    if (r[1:0] === 2'h3) n_fail++;
  endtask : wait_res
  task automatic wait_irq;
    w = 0;
    while (touch_irq_n !== 1'b0 && w < 60) begin
      @(posedge core_clk);
      w++;
    end
    if (touch_irq_n !== 1'b0) n_fail++;
  endtask : wait_irq
  function automatic logic [31:0] ew(input logic [1:0] k, input logic [1:0] e);
    return {16'h0, k, 10'h2a5, k, e};
  endfunction : ew
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd_chk(`TICS_A_CTRL, 32'h30);
    rd_chk(`TICS_A_EPULSE, 32'h100);
    rd_chk(`TICS_A_PUTIME, 32'h40);
    rd_chk(`TICS_A_APER, 32'h10);
    rd_chk(8'h40, 32'h0);
    rd_chk(`TICS_A_FIFO, 32'hffff);
    rd_chk(`TICS_A_STATUS, 32'h10);
    chk({31'h0, panel_tdm}, 32'h1);
    bus(1'b1, `TICS_A_CTRL, 32'h0);
    bus(1'b1, `TICS_A_EPULSE, 32'h4);
    bus(1'b1, `TICS_A_PUTIME, 32'h4);
    touch_det <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({31'h0, touch_irq_n}, 32'h0);
    rd_chk(`TICS_A_STATUS, 32'h13);
    bus(1'b1, `TICS_A_CMD, `TICS_CMD_XY);
    rd_chk(8'h20, `TICS_PEND_WORD);
    wait_res(8'h24);
    for (int k = 0; k < 2; k++) rd_chk({4'h2, k[1:0], 2'h0}, ew(k[1:0], 2'h0));
    chk({31'h0, touch_irq_n}, 32'h0);
    touch_det <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk({31'h0, touch_irq_n}, 32'h1);
    rd_chk(8'h20, ew(2'h0, 2'h0));
    bus(1'b1, `TICS_A_CMD, `TICS_CMD_XYZ);
    wait_res(8'h2c);
    for (int k = 0; k < 4; k++) rd_chk({4'h2, k[1:0], 2'h0}, ew(k[1:0], 2'h2));
    bus(1'b1, `TICS_A_CMD, 32'h79);
    wait_res(8'h20);
    st_chk(3'h2);
    chk({31'h0, panel_drive}, 32'h1);
    bus(1'b1, `TICS_A_CMD, 32'h78);
    wait_res(8'h20);
    chk(r, ew(2'h0, 2'h2));
    st_chk(3'h0);
    bus(1'b1, `TICS_A_CMD, 32'h6b);
    st_chk(3'h2);
    bus(1'b1, `TICS_A_CMD, 32'h78);
    st_chk(3'h0);
    // Edge mode with a slow converter
    bus(1'b1, `TICS_A_CTRL, 32'h1);
    slow <= 1'b1;
    touch_det <= 1'b1;
    wait_irq;
    n = 0;
    while (touch_irq_n === 1'b0 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    chk(n, 32'h4);
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, `TICS_A_CMD, 32'h78);
      wait_res(8'h20);
      chk(r, ew(2'h0, e[1:0]));
      st_chk(3'h1);
    end
    touch_det <= 1'b0;
    repeat (8) @(posedge core_clk);
    touch_det <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk({31'h0, touch_irq_n}, 32'h1);
    touch_det <= 1'b0;
    bus(1'b1, `TICS_A_CMD, 32'h78);
    wait_res(8'h20);
    chk(r, ew(2'h0, 2'h2));
    st_chk(3'h0);
    touch_det <= 1'b1;
    wait_irq;
    chk({31'h0, touch_irq_n}, 32'h0);
    // Autonomous mode, X and Y
    touch_det <= 1'b0;
    bus(1'b1, `TICS_A_CTRL, 32'h32);
    bus(1'b1, `TICS_A_CMD, 32'h78);
    st_chk(3'h0);
    touch_det <= 1'b1;
    w = 0;
    do begin
      bus(1'b0, `TICS_A_FCNT, 32'h0);
      w++;
    end while (r < 32'h2 && w < 200);
    touch_det <= 1'b0;
    w = 0;
    do begin
      bus(1'b0, `TICS_A_STATUS, 32'h0);
      w++;
    end while (r[10:8] !== 3'h0 && w < 200);
    chk({29'h0, r[10:8]}, 32'h0);
    bus(1'b0, `TICS_A_FCNT, 32'h0);
    n = r;
    chk({31'h0, n >= 2}, 32'h1);
    for (int i = 0; i < n; i++) begin
      bus(1'b0, `TICS_A_FIFO, 32'h0);
      chk({18'h0, r[15:2]}, ew(i[1:0] & 2'h1, 2'h0) >> 2);
    end
    rd_chk(`TICS_A_FIFO, 32'hffff);
    // Aperture on: repeated rounds at one position push only the first X and Y
    bus(1'b1, `TICS_A_CTRL, 32'h36);
    touch_det <= 1'b1;
    repeat (150) @(posedge core_clk);
    rd_chk(`TICS_A_FCNT, 32'h2);
    report_and_stop;
  end
endmodule : tics_touch_seq_tb
